// file: core/tag_snoop_mirror.sv
/*
 * Per-frame forwarding and tag edit decision for the processor port of a
 * three-port switch, with an AHB-Lite register slave.
 * Assumes a parser delivers one descriptor per frame, synchronous to hclk,
 * and an egress editor applies the returned per-port edits and CRC.
 */
// Added by the designer: the address map and register access over AHB-Lite.
// How it works
// - Special tagging needs both the global and the port 3 enable bits.
// - Special identifier is 0x810 plus a 4-bit mask, in the TPID slot.
// - Special identifiers appear only on port 3, never on ports 1 or 2.
// - Mask 0001 sends to port 1, 0010 to port 2, 0011 to both.
// - Zero mask or untagged processor frames use the normal lookup.
// - A non-zero mask overrides lookup and all spanning tree states.
// - Insert set or both clear: rewrite to 0x8100, fix null VID, new CRC.
// - Removal only: strip tag, pad to 64 bytes, recompute CRC.
// - Frames to the processor carry mask 0001 or 0010 by source.
// - Tagged frames to processor: special identifier, fix null VID, CRC.
// - Untagged frames to processor: insert special identifier and PVID TCI.
// - IGMP snooping traps IPv4 protocol 2 frames to port 3 only.
// - Static multicast entries limit forwarding to subscribed ports.
// - MLD snooping has an enable and an option bit, needs special tagging.
// - MLD traps IPv6 multicast, hop limit 1, next header 1 or 58.
// - Option bit adds next headers 43, 44, 50, 51, 60.
// - Receive sniff copies received frames, errored ones optionally.
// - Transmit sniff copies transmitted frames to the sniffer.
// - AND mode mirrors only frames both rx-sniffed and tx-sniffed.
// - Sniff roles are per port; any port may be the sniffer.
`timescale 1ns/1ps
`default_nettype none

module tag_snoop_mirror (
	input  wire logic                         hclk,
	input  wire logic                         hresetn,
	input  wire logic                         ce,
	input  wire logic                         hsel,
	input  wire logic [31:0]                  haddr,
	input  wire logic [1:0]                   htrans,
	input  wire logic                         hwrite,
	input  wire logic [2:0]                   hsize,
	input  wire logic                         hready,
	input  wire logic [31:0]                  hwdata,
	output logic      [31:0]                  hrdata,
	output logic                              hreadyout,
	output logic                              hresp,
	input  wire logic                         desc_valid,
	input  wire tag_snoop_pkg::frame_desc_t   desc,
	output logic                              res_valid,
	output tag_snoop_pkg::frame_res_t         res
);
	// ***********************************************
	// State
	// ***********************************************
	tag_snoop_pkg::state_t     s_reg;
	tag_snoop_pkg::state_t     s_next;
	tag_snoop_pkg::port_edit_t edits [3];
	tag_snoop_pkg::frame_res_t dec;

	logic [2:0]  src_oh;
	logic [3:0]  src_mask;
	logic [1:0]  mask_ports;
	logic [11:0] src_pvid;
	logic [11:0] cpu_pvid;
	logic [2:0]  txsn_vec;
	logic [2:0]  sniffer_vec;
	logic [2:0]  rem_vec;
	logic [2:0]  ins_vec;
	logic [2:0]  normal_dst;
	logic [2:0]  dst;
	logic [2:0]  sniff_dst;
	logic        special_on;
	logic        from_cpu;
	logic        std_tag;
	logic        spec_tag;
	logic        override;
	logic        good;
	logic        igmp_hit;
	logic        mld_hit;
	logic        trap;
	logic        rx_sn;
	logic        tx_sn;
	logic        mirror;
	logic        short_frame;

	function automatic logic nh_basic(input logic [7:0] nh);
		nh_basic = (nh == tag_snoop_pkg::NH_ICMP) || (nh == tag_snoop_pkg::NH_ICMPV6);
	endfunction

	function automatic logic nh_extra(input logic [7:0] nh);
		nh_extra = (nh == tag_snoop_pkg::NH_ROUTING) || (nh == tag_snoop_pkg::NH_FRAGMENT)
			|| (nh == tag_snoop_pkg::NH_ESP) || (nh == tag_snoop_pkg::NH_AUTH)
			|| (nh == tag_snoop_pkg::NH_DEST_OPT);
	endfunction

	function automatic tag_snoop_pkg::tci_t fix_vid(input tag_snoop_pkg::tci_t t,
			input logic [11:0] pvid);
		fix_vid = t;
		if (t.vid == tag_snoop_pkg::VID_NULL) begin
			fix_vid.vid = pvid;
		end
	endfunction

	// ***********************************************
	// Classification
	// ***********************************************
	assign special_on  = s_reg.gctl.stag_en & s_reg.pcfg[tag_snoop_pkg::CPU_IDX].stag_en;
	assign from_cpu    = (desc.src == tag_snoop_pkg::CPU_IDX);
	assign src_oh      = 3'(tag_snoop_pkg::ONE_OH << desc.src);
	assign src_mask    = {1'b0, src_oh};
	assign src_pvid    = s_reg.pcfg[desc.src].pvid;
	assign cpu_pvid    = s_reg.pcfg[tag_snoop_pkg::CPU_IDX].pvid;
	assign std_tag     = desc.tag_seen && (desc.tpid == tag_snoop_pkg::TPID_8021Q);
	// Only the processor port may carry a special identifier
	assign spec_tag    = special_on && from_cpu && desc.tag_seen
		&& (desc.tpid[15:4] == tag_snoop_pkg::STAG_PREFIX);
	assign mask_ports  = desc.tpid[1:0];
	assign override    = spec_tag && (desc.tpid[3:0] != tag_snoop_pkg::MASK_NONE);
	assign good        = !desc.rx_error;
	assign short_frame = desc.frame_len < tag_snoop_pkg::PAD_LIMIT;

	assign igmp_hit = s_reg.gctl.igmp_en && desc.is_ip && (desc.ip_ver == tag_snoop_pkg::IP_V4)
		&& (desc.ip_proto == tag_snoop_pkg::PROTO_IGMP);
	assign mld_hit = s_reg.gctl.mld_en && special_on && desc.ipv6_mcast
		&& (desc.hop_limit == tag_snoop_pkg::HOP_LIMIT_MLD)
		&& (nh_basic(desc.next_hdr)
		|| ((desc.next_hdr == tag_snoop_pkg::NH_HOP_BY_HOP) && nh_basic(desc.hbh_next_hdr))
		|| (s_reg.gctl.mld_opt && (nh_extra(desc.next_hdr)
		|| ((desc.next_hdr == tag_snoop_pkg::NH_HOP_BY_HOP) && nh_extra(desc.hbh_next_hdr)))));
	assign trap = !from_cpu && (igmp_hit || mld_hit);

	// ***********************************************
	// Forwarding and mirroring
	// ***********************************************
	// Static multicast entries arrive already resolved in the lookup vector
	assign normal_dst = desc.lookup & desc.fwd_ok & ~src_oh;

	always_comb begin
		dst = normal_dst;
		if (!good) begin
			dst = '0;
		end else if (override) begin
			// Bypasses the spanning tree gating on purpose
			dst = {1'b0, mask_ports};
		end else if (trap) begin
			dst = tag_snoop_pkg::CPU_OH;
		end
	end

	assign rx_sn     = s_reg.pcfg[desc.src].rx_sniff && (good || s_reg.gctl.sniff_bad);
	assign tx_sn     = |(dst & txsn_vec);
	assign mirror    = s_reg.gctl.mirror_and ? (rx_sn && tx_sn) : (rx_sn || tx_sn);
	assign sniff_dst = sniffer_vec & ~src_oh;

	// ***********************************************
	// Per-port tag edits
	// ***********************************************
	for (genvar g = 0; g < tag_snoop_pkg::NPORT; g++) begin : g_port
		localparam logic [1:0] PIDX = 2'(g);
		assign txsn_vec[g]    = s_reg.pcfg[g].tx_sniff;
		assign sniffer_vec[g] = s_reg.pcfg[g].sniffer;
		assign rem_vec[g]     = s_reg.pcfg[g].tag_rem;
		assign ins_vec[g]     = s_reg.pcfg[g].tag_ins;

		always_comb begin
			edits[g] = '{op: tag_snoop_pkg::OP_KEEP, tpid: desc.tpid, tci: desc.tci,
				pad: 1'b0, crc: 1'b0};
			if ((PIDX == tag_snoop_pkg::CPU_IDX) && special_on && !from_cpu) begin
				edits[g].tpid = {tag_snoop_pkg::STAG_PREFIX, src_mask};
				if (std_tag) begin
					edits[g].op  = tag_snoop_pkg::OP_REWRITE;
					edits[g].tci = fix_vid(desc.tci, src_pvid);
				end else begin
					edits[g].op  = tag_snoop_pkg::OP_INSERT;
					edits[g].tci = '{pcp: '0, cfi: 1'b0, vid: src_pvid};
				end
			end else if (spec_tag) begin
				if (rem_vec[g] && !ins_vec[g]) begin
					edits[g].op  = tag_snoop_pkg::OP_STRIP;
					edits[g].pad = short_frame;
				end else begin
					edits[g].op   = tag_snoop_pkg::OP_REWRITE;
					edits[g].tpid = tag_snoop_pkg::TPID_8021Q;
					edits[g].tci  = fix_vid(desc.tci, cpu_pvid);
				end
			end else if (std_tag && rem_vec[g] && !ins_vec[g]) begin
				edits[g].op  = tag_snoop_pkg::OP_STRIP;
				edits[g].pad = short_frame;
			end else if (!std_tag && ins_vec[g]) begin
				// Processor frames keep a stray 0x810x word as payload here
				edits[g].op   = tag_snoop_pkg::OP_INSERT;
				edits[g].tpid = tag_snoop_pkg::TPID_8021Q;
				edits[g].tci  = '{pcp: '0, cfi: 1'b0, vid: src_pvid};
			end
			edits[g].crc = (edits[g].op != tag_snoop_pkg::OP_KEEP);
		end
	end

	always_comb begin
		dec          = '0;
		dec.egress   = dst | (mirror ? sniff_dst : 3'h0);
		dec.mirrored = mirror;
		dec.trapped  = good && !override && trap;
		for (int i = 0; i < tag_snoop_pkg::NPORT; i++) begin
			dec.edit[i] = edits[i];
		end
	end

	// ***********************************************
	// Register slave and next state
	// ***********************************************
	always_comb begin
		s_next = s_reg;
		// Write data phase; lands before a read in the same cycle
		if (s_reg.wr_pend) begin
			if (s_reg.wr_addr == tag_snoop_pkg::OFS_GCTL) begin
				s_next.gctl     = tag_snoop_pkg::gctl_t'(hwdata);
				s_next.gctl.rsv = '0;
			end
			for (int i = 0; i < tag_snoop_pkg::NPORT; i++) begin
				if (s_reg.wr_addr == 5'(int'(tag_snoop_pkg::OFS_PCFG_BASE)
						+ i * int'(tag_snoop_pkg::REG_STRIDE))) begin
					s_next.pcfg[i]        = tag_snoop_pkg::pcfg_t'(hwdata);
					s_next.pcfg[i].rsv_hi = '0;
					s_next.pcfg[i].rsv_lo = '0;
				end
			end
		end
		s_next.wr_pend   = 1'b0;
		s_next.hreadyout = 1'b1;
		s_next.hresp     = 1'b0;
		if (desc_valid) begin
			s_next.res       = dec;
			s_next.frame_cnt = s_reg.frame_cnt + tag_snoop_pkg::CNT_STEP;
		end
		s_next.res_valid = desc_valid;
		if (hsel && hready && (htrans == tag_snoop_pkg::HTRANS_NONSEQ)) begin
			s_next.wr_pend = hwrite;
			s_next.wr_addr = haddr[tag_snoop_pkg::ADDR_W-1:0];
			if (!hwrite) begin
				// Unmapped offsets read as zero
				s_next.hrdata = '0;
				if (haddr[tag_snoop_pkg::ADDR_W-1:0] == tag_snoop_pkg::OFS_GCTL) begin
					s_next.hrdata = s_next.gctl;
				end
				if (haddr[tag_snoop_pkg::ADDR_W-1:0] == tag_snoop_pkg::OFS_STAT) begin
					s_next.hrdata = {tag_snoop_pkg::STAT_RSV, s_next.frame_cnt};
				end
				for (int i = 0; i < tag_snoop_pkg::NPORT; i++) begin
					if (haddr[tag_snoop_pkg::ADDR_W-1:0] == 5'(int'(tag_snoop_pkg::OFS_PCFG_BASE)
							+ i * int'(tag_snoop_pkg::REG_STRIDE))) begin
						s_next.hrdata = s_next.pcfg[i];
					end
				end
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s_reg           <= '0;
			s_reg.hreadyout <= 1'b1;
			s_reg.pcfg      <= {3{tag_snoop_pkg::PCFG_RST}};
		end else if (ce) begin
			s_reg <= s_next;
		end
	end

	assign hrdata    = s_reg.hrdata;
	assign hreadyout = s_reg.hreadyout;
	assign hresp     = s_reg.hresp;
	assign res_valid = s_reg.res_valid;
	assign res       = s_reg.res;

	// ***********************************************
	// Assertions
	// ***********************************************
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	logic acc;
	assign acc = ce && desc_valid;

	override_dest_a: assert property (acc && override |=>
		((res.egress[1:0] & $past(mask_ports)) == $past(mask_ports)))
		else $error("port mask not honoured");
	special_off_a: assert property (acc && !special_on |=>
		(res.edit[0].op != tag_snoop_pkg::OP_REWRITE) && (res.edit[1].op != tag_snoop_pkg::OP_REWRITE)
		&& (res.edit[2].op != tag_snoop_pkg::OP_REWRITE))
		else $error("tag rewritten while special tagging off");
	// A stripped frame carries no tag, so its tpid field means nothing
	no_stag_out_a: assert property (acc && spec_tag |=>
		(res.edit[0].op inside {tag_snoop_pkg::OP_REWRITE, tag_snoop_pkg::OP_STRIP})
		&& (res.edit[1].op inside {tag_snoop_pkg::OP_REWRITE, tag_snoop_pkg::OP_STRIP})
		&& ((res.edit[0].op == tag_snoop_pkg::OP_STRIP)
		|| (res.edit[0].tpid == tag_snoop_pkg::TPID_8021Q))
		&& ((res.edit[1].op == tag_snoop_pkg::OP_STRIP)
		|| (res.edit[1].tpid == tag_snoop_pkg::TPID_8021Q)))
		else $error("special identifier left on a network port");
	cpu_mask_a: assert property (acc && special_on && !from_cpu |=>
		(res.edit[2].tpid == {tag_snoop_pkg::STAG_PREFIX, $past(src_mask)}) && res.edit[2].crc)
		else $error("wrong source mask toward processor");
	null_vid_a: assert property (acc && spec_tag && !(rem_vec[0] && !ins_vec[0]) &&
		(desc.tci.vid == tag_snoop_pkg::VID_NULL) |=> (res.edit[0].tci.vid == $past(cpu_pvid)))
		else $error("null VID not replaced");
	strip_pad_a: assert property (acc && spec_tag && rem_vec[1] && !ins_vec[1] |=>
		(res.edit[1].op == tag_snoop_pkg::OP_STRIP) && (res.edit[1].pad == $past(short_frame))
		&& res.edit[1].crc)
		else $error("strip or pad wrong");
	cpu_insert_a: assert property (acc && special_on && !from_cpu && !std_tag |=>
		(res.edit[2].op == tag_snoop_pkg::OP_INSERT) && (res.edit[2].tci.vid == $past(src_pvid)))
		else $error("ingress VID not inserted toward processor");
	cpu_vid_a: assert property (acc && special_on && !from_cpu && std_tag &&
		(desc.tci.vid == tag_snoop_pkg::VID_NULL) |=> (res.edit[2].tci.vid == $past(src_pvid)))
		else $error("null VID not replaced toward processor");
	bad_frame_a: assert property (acc && !good && !s_reg.gctl.sniff_bad |=>
		!res.mirrored && (res.egress == 3'h0))
		else $error("errored frame forwarded");
	igmp_trap_a: assert property (acc && igmp_hit && !from_cpu && good && !mirror |=>
		(res.egress == tag_snoop_pkg::CPU_OH) && res.trapped)
		else $error("IGMP frame not trapped");
	mld_trap_a: assert property (acc && mld_hit && !from_cpu && good && !mirror |=>
		(res.egress == tag_snoop_pkg::CPU_OH) && res.trapped)
		else $error("MLD frame not trapped");
	lookup_use_a: assert property (acc && from_cpu && !override && good |=>
		res.mirrored || (res.egress == $past(normal_dst)))
		else $error("lookup result not used");
	and_mirror_a: assert property (acc && s_reg.gctl.mirror_and && !(rx_sn && tx_sn) |=>
		!res.mirrored)
		else $error("AND mirror copied a frame");
	rx_mirror_a: assert property (acc && !s_reg.gctl.mirror_and && rx_sn |=>
		res.mirrored && ((res.egress & $past(sniff_dst)) == $past(sniff_dst)))
		else $error("receive sniff copy missing");
	tx_mirror_a: assert property (acc && !s_reg.gctl.mirror_and && tx_sn |=> res.mirrored)
		else $error("transmit sniff copy missing");

	override_c: cover property (acc && override ##1 res_valid);
	igmp_c:     cover property (acc && igmp_hit && !from_cpu ##1 res.trapped);
	mld_c:      cover property (acc && mld_hit && s_reg.gctl.mld_opt ##1 res.trapped);
	and_c:      cover property (acc && s_reg.gctl.mirror_and && rx_sn && tx_sn ##1 res.mirrored);
	bad_c:      cover property (acc && !good && s_reg.gctl.sniff_bad ##1 res.mirrored);
endmodule

`default_nettype wire

// file: core/tag_snoop_pkg.sv
/*
 * Shared constants, register layouts and frame descriptor types for the
 * processor port tagging, snooping and mirroring block.
 * Assumes a frame parser ahead of it and an egress editor after it.
 */
package tag_snoop_pkg;
	// ***********************************************
	// Ports and tag constants
	// ***********************************************
	localparam int          NPORT         = 3;
	localparam logic [1:0]  CPU_IDX       = 2'h2;
	localparam logic [2:0]  CPU_OH        = 3'h4;
	localparam logic [2:0]  ONE_OH        = 3'h1;
	localparam logic [15:0] TPID_8021Q    = 16'h8100;
	localparam logic [11:0] STAG_PREFIX   = 12'h810;
	localparam logic [3:0]  MASK_NONE     = 4'h0;
	localparam logic [11:0] VID_NULL      = 12'h000;
	localparam logic [11:0] PVID_RST      = 12'h001;
	localparam logic [10:0] MIN_FRAME     = 11'h040;
	localparam logic [10:0] TAG_BYTES     = 11'h004;
	localparam logic [10:0] PAD_LIMIT     = MIN_FRAME + TAG_BYTES;
	// ***********************************************
	// Snooping match values
	// ***********************************************
	localparam logic [3:0]  IP_V4         = 4'h4;
	localparam logic [7:0]  PROTO_IGMP    = 8'h02;
	localparam logic [7:0]  HOP_LIMIT_MLD = 8'h01;
	localparam logic [7:0]  NH_HOP_BY_HOP = 8'h00;
	localparam logic [7:0]  NH_ICMP       = 8'h01;
	localparam logic [7:0]  NH_ICMPV6     = 8'h3a;
	localparam logic [7:0]  NH_ROUTING    = 8'h2b;
	localparam logic [7:0]  NH_FRAGMENT   = 8'h2c;
	localparam logic [7:0]  NH_ESP        = 8'h32;
	localparam logic [7:0]  NH_AUTH       = 8'h33;
	localparam logic [7:0]  NH_DEST_OPT   = 8'h3c;
	// ***********************************************
	// Register map
	// ***********************************************
	localparam int          ADDR_W        = 5;
	localparam logic [4:0]  OFS_GCTL      = 5'h00;
	localparam logic [4:0]  OFS_PCFG_BASE = 5'h04;
	localparam logic [4:0]  REG_STRIDE    = 5'h04;
	localparam logic [4:0]  OFS_STAT      = 5'h10;
	localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
	localparam logic [15:0] CNT_STEP      = 16'h0001;
	localparam logic [15:0] STAT_RSV      = 16'h0000;

	typedef enum logic [3:0] {
		OP_KEEP    = 4'h1,
		OP_REWRITE = 4'h2,
		OP_INSERT  = 4'h4,
		OP_STRIP   = 4'h8
	} edit_op_t;

	typedef struct packed {
		logic [2:0]  pcp;
		logic        cfi;
		logic [11:0] vid;
	} tci_t;

	typedef struct packed {
		logic [25:0] rsv;
		logic        sniff_bad;
		logic        mirror_and;
		logic        mld_opt;
		logic        mld_en;
		logic        igmp_en;
		logic        stag_en;
	} gctl_t;

	typedef struct packed {
		logic [3:0]  rsv_hi;
		logic [11:0] pvid;
		logic [9:0]  rsv_lo;
		logic        stag_en;
		logic        sniffer;
		logic        tx_sniff;
		logic        rx_sniff;
		logic        tag_rem;
		logic        tag_ins;
	} pcfg_t;

	localparam pcfg_t PCFG_RST = '{pvid: PVID_RST, default: '0};

	typedef struct packed {
		logic [1:0]  src;
		logic        tag_seen;
		logic [15:0] tpid;
		tci_t        tci;
		logic [2:0]  lookup;
		logic [2:0]  fwd_ok;
		logic        rx_error;
		logic [10:0] frame_len;
		logic        is_ip;
		logic [3:0]  ip_ver;
		logic [7:0]  ip_proto;
		logic        ipv6_mcast;
		logic [7:0]  hop_limit;
		logic [7:0]  next_hdr;
		logic [7:0]  hbh_next_hdr;
	} frame_desc_t;

	typedef struct packed {
		edit_op_t    op;
		logic [15:0] tpid;
		tci_t        tci;
		logic        pad;
		logic        crc;
	} port_edit_t;

	typedef struct packed {
		logic [2:0]       egress;
		logic             mirrored;
		logic             trapped;
		port_edit_t [2:0] edit;
	} frame_res_t;

	typedef struct packed {
		logic             wr_pend;
		logic [4:0]       wr_addr;
		gctl_t            gctl;
		pcfg_t [2:0]      pcfg;
		logic [15:0]      frame_cnt;
		logic [31:0]      hrdata;
		logic             hreadyout;
		logic             hresp;
		logic             res_valid;
		frame_res_t       res;
	} state_t;
endpackage

// file: tb/host_port_model.sv
/*
 * Host processor side model: hands frame descriptors to the block and
 * collects the per-frame result. Assumes the block answers one cycle after
 * it takes a descriptor, with no backpressure.
 */
`timescale 1ns/1ps
`default_nettype none

module host_port_model (
	input  wire logic                      hclk,
	output logic                           desc_valid,
	output tag_snoop_pkg::frame_desc_t     desc,
	input  wire logic                      res_valid,
	input  wire tag_snoop_pkg::frame_res_t res
);
	// ***********************************************
	// Frame hand-off
	// ***********************************************
	initial begin
		desc_valid = 1'b0;
		desc = '0;
	end

	// Special identifier with a steering mask
	function automatic logic [15:0] stag(input logic [3:0] mask);
		return {tag_snoop_pkg::STAG_PREFIX, mask};
	endfunction

	// Idle fields are inverted so a stale descriptor is never trusted
	task automatic send(input tag_snoop_pkg::frame_desc_t d,
		output tag_snoop_pkg::frame_res_t r, output logic ok);
		@(posedge hclk);
		desc_valid <= 1'b1;
		desc       <= d;
		@(posedge hclk);
		desc_valid <= 1'b0;
		desc       <= tag_snoop_pkg::frame_desc_t'(~d);
		// Result valid stands one cycle only; look at it mid-cycle
		@(negedge hclk);
		ok = res_valid;
		r = res;
	endtask
endmodule

`default_nettype wire

// file: tb/cpu_port_tagging_snoop_mirror_tb.sv
/*
 * Self-checking bench for the processor port tag, snoop and mirror block.
 * Assumes a single zero-wait AHB-Lite slave and the host model beside it.
 */
`timescale 1ns/1ps
`default_nettype none

module cpu_port_tagging_snoop_mirror_tb;
	logic                        hclk    = 1'b0;
	logic                        hresetn = 1'b0;
	logic                        ce      = 1'b1;
	logic                        hsel    = 1'b0;
	logic [31:0]                 haddr   = 32'h0;
	logic [1:0]                  htrans  = 2'h0;
	logic                        hwrite  = 1'b0;
	logic [2:0]                  hsize   = 3'h2;
	logic [31:0]                 hwdata  = 32'h0;
	logic [31:0]                 hrdata;
	logic                        hreadyout;
	logic                        hresp;
	logic                        desc_valid;
	tag_snoop_pkg::frame_desc_t  desc;
	logic                        res_valid;
	tag_snoop_pkg::frame_res_t   res;
	tag_snoop_pkg::frame_res_t   r;
	tag_snoop_pkg::frame_desc_t  d;
	logic [15:0]                 sent = 16'h0;
	int                          failures = 0;
	int                          comparisons = 0;

	always #5 hclk = ~hclk;

	tag_snoop_mirror i_dut (.hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .desc_valid(desc_valid),
		.desc(desc), .res_valid(res_valid), .res(res));

	host_port_model i_host (.hclk(hclk), .desc_valid(desc_valid), .desc(desc),
		.res_valid(res_valid), .res(res));

	// ***********************************************
	// Shared tasks
	// ***********************************************
	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		comparisons++;
		if (got !== exp) begin
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
			failures++;
		end
	endtask

	// One single transfer; waits on hready in both phases, the watchdog bounds it
	task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd,
		output logic [31:0] rd);
		@(posedge hclk);
		hsel   <= 1'b1;
		htrans <= tag_snoop_pkg::HTRANS_NONSEQ;
		haddr  <= a;
		hwrite <= wr;
		do begin
			@(posedge hclk);
		end while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= wd;
		do begin
			@(posedge hclk);
		end while (hreadyout !== 1'b1);
		rd = hrdata;
		hsel <= 1'b0;
		chk(hresp, 1'b0);
	endtask

	task automatic wr(input logic [31:0] a, input logic [31:0] v);
		logic [31:0] t;
		bus(1'b1, a, v, t);
	endtask

	task automatic rdchk(input logic [31:0] a, input logic [31:0] exp);
		logic [31:0] t;
		bus(1'b0, a, 32'h0, t);
		chk(t, exp);
	endtask

	function automatic tag_snoop_pkg::frame_desc_t mk(input logic [1:0] src, input logic tg,
		input logic [15:0] tpid, input logic [2:0] lookup);
		tag_snoop_pkg::frame_desc_t x;
		x = '0;
		x.src = src;
		x.tag_seen = tg;
		x.tpid = tpid;
		x.tci = '{pcp: 3'h5, cfi: 1'b0, vid: 12'h000};
		x.lookup = lookup;
		x.fwd_ok = 3'h7;
		x.frame_len = 11'h064;
		return x;
	endfunction

	task automatic frame(input tag_snoop_pkg::frame_desc_t f, input logic [2:0] eg,
		input logic mir, input logic trp);
		logic ok;
		i_host.send(f, r, ok);
		sent++;
		chk(ok, 1'b1);
		chk(r.egress, eg);
		chk(r.mirrored, mir);
		chk(r.trapped, trp);
	endtask

	// ***********************************************
	// Scenarios
	// ***********************************************
	task automatic t_regs;
		rdchk(32'h00, 32'h0);
		rdchk(32'h04, 32'h0001_0000);
		rdchk(32'h0c, 32'h0001_0000);
		wr(32'h14, 32'hffff_ffff);
		rdchk(32'h14, 32'h0);
		wr(32'h00, 32'hffff_ffff);
		rdchk(32'h00, 32'h0000_003f);
		wr(32'h00, 32'h0000_0001);
	endtask

	task automatic t_from_cpu;
		logic [3:0] m;
		// Port 3 enable still clear: identifier is an ordinary word
		frame(mk(2'h2, 1'b1, i_host.stag(4'h1), 3'h2), 3'h2, 1'b0, 1'b0);
		wr(32'h0c, 32'h0123_0020);
		wr(32'h04, 32'h0011_0000);
		wr(32'h08, 32'h0002_0002);
		for (int i = 0; i < 4; i++) begin
			m = 4'(i);
			d = mk(2'h2, 1'b1, i_host.stag(m), 3'h2);
			d.fwd_ok = (m == 4'h0) ? 3'h7 : 3'h0;
			d.frame_len = 11'h040;
			frame(d, (m == 4'h0) ? 3'h2 : {1'b0, m[1:0]}, 1'b0, 1'b0);
		end
		d = mk(2'h2, 1'b1, i_host.stag(4'h3), 3'h0);
		d.frame_len = 11'h040;
		frame(d, 3'h3, 1'b0, 1'b0);
		chk(r.edit[0].op, tag_snoop_pkg::OP_REWRITE);
		chk(r.edit[0].tpid, 16'h8100);
		chk(r.edit[0].tci, {3'h5, 1'b0, 12'h123});
		chk(r.edit[0].crc, 1'b1);
		chk({r.edit[1].op, r.edit[1].pad, r.edit[1].crc}, {tag_snoop_pkg::OP_STRIP, 2'h3});
		d.frame_len = 11'h044;
		frame(d, 3'h3, 1'b0, 1'b0);
		chk(r.edit[1].pad, 1'b0);
		frame(mk(2'h2, 1'b0, 16'h0800, 3'h1), 3'h1, 1'b0, 1'b0);
	endtask

	task automatic t_to_cpu;
		frame(mk(2'h0, 1'b1, 16'h8100, 3'h4), 3'h4, 1'b0, 1'b0);
		chk(r.edit[2].op, tag_snoop_pkg::OP_REWRITE);
		chk(r.edit[2].tpid, 16'h8101);
		chk(r.edit[2].tci, {3'h5, 1'b0, 12'h011});
		frame(mk(2'h1, 1'b0, 16'h0800, 3'h4), 3'h4, 1'b0, 1'b0);
		chk(r.edit[2].op, tag_snoop_pkg::OP_INSERT);
		chk({r.edit[2].tpid, r.edit[2].crc}, {16'h8102, 1'b1});
		chk(r.edit[2].tci, {4'h0, 12'h002});
	endtask

	task automatic t_snoop;
		logic [31:0] rows [10] = '{32'h053a0003, 32'h05000103, 32'h052b0002, 32'h0d2b0003,
			32'h0d003c03, 32'h0d2c0003, 32'h0d320003, 32'h0d003303, 32'h053a0004, 32'h043a0002};
		wr(32'h00, 32'h0000_0003);
		d = mk(2'h0, 1'b0, 16'h0800, 3'h2);
		d.is_ip = 1'b1;
		d.ip_ver = 4'h4;
		d.ip_proto = 8'h02;
		frame(d, 3'h4, 1'b0, 1'b1);
		d.ip_proto = 8'h06;
		frame(d, 3'h2, 1'b0, 1'b0);
		foreach (rows[i]) begin
			wr(32'h00, {24'h0, rows[i][31:24]});
			d = mk(2'h0, 1'b0, 16'h86dd, 3'h2);
			d.ipv6_mcast = 1'b1;
			d.next_hdr = rows[i][23:16];
			d.hbh_next_hdr = rows[i][15:8];
			d.hop_limit = {1'b0, rows[i][7:1]};
			frame(d, rows[i][0] ? 3'h4 : 3'h2, 1'b0, rows[i][0]);
		end
	endtask

	task automatic t_mirror;
		logic ok;
		wr(32'h00, 32'h0000_0001);
		wr(32'h04, 32'h0011_0004);
		wr(32'h0c, 32'h0123_0030);
		frame(mk(2'h0, 1'b0, 16'h0800, 3'h2), 3'h6, 1'b1, 1'b0);
		wr(32'h04, 32'h0011_0008);
		frame(mk(2'h1, 1'b0, 16'h0800, 3'h1), 3'h5, 1'b1, 1'b0);
		wr(32'h00, 32'h0000_0011);
		wr(32'h04, 32'h0011_0004);
		wr(32'h08, 32'h0002_0008);
		frame(mk(2'h0, 1'b0, 16'h0800, 3'h2), 3'h6, 1'b1, 1'b0);
		frame(mk(2'h1, 1'b0, 16'h0800, 3'h1), 3'h1, 1'b0, 1'b0);
		wr(32'h00, 32'h0000_0001);
		d = mk(2'h0, 1'b0, 16'h0800, 3'h2);
		d.rx_error = 1'b1;
		frame(d, 3'h0, 1'b0, 1'b0);
		wr(32'h00, 32'h0000_0021);
		frame(d, 3'h4, 1'b1, 1'b0);
		// Frozen block takes no descriptor and keeps its count
		@(posedge hclk);
		ce <= 1'b0;
		i_host.send(d, r, ok);
		chk(ok, 1'b0);
		@(posedge hclk);
		ce <= 1'b1;
		wr(32'h10, 32'hffff_ffff);
		rdchk(32'h10, {16'h0, sent});
	endtask

	// ***********************************************
	// Run control
	// ***********************************************
	task automatic close_out;
		$display("failures %0d comparisons %0d", failures, comparisons);
		if (failures == 0 && comparisons > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	initial begin
		repeat (5) @(posedge hclk);
		hresetn <= 1'b1;
		t_regs();
		t_from_cpu();
		t_to_cpu();
		t_snoop();
		t_mirror();
		close_out();
	end

	// Whole run is under two hundred cycles; this leaves wide margin
	initial begin
		#100000;
		failures++;
		close_out();
	end
endmodule

`default_nettype wire
